// ==== rtl/sfcd_pkg.sv ====
package sfcd_pkg;

  localparam int BYTE_BITS = 8;
  localparam int SEQ_LEN   = 4;

  // single-byte opcodes
  localparam logic [7:0] OP_PAGE_RD = 8'hd2, OP_RD_LP = 8'h01;
  localparam logic [7:0] OP_RD_LF = 8'h03, OP_RD_HF = 8'h0b;
  localparam logic [7:0] OP_RD_HF2 = 8'h1b, OP_RD_X2 = 8'h3b;
  localparam logic [7:0] OP_RD_X4 = 8'h6b, OP_RD_LEG = 8'he8;
  localparam logic [7:0] OP_B1_RD_LF = 8'hd1, OP_B2_RD_LF = 8'hd3;
  localparam logic [7:0] OP_B1_RD_HF = 8'hd4, OP_B2_RD_HF = 8'hd6;
  localparam logic [7:0] OP_B1_WR = 8'h84, OP_B2_WR = 8'h87;
  localparam logic [7:0] OP_B1_WR_X2 = 8'h24, OP_B2_WR_X2 = 8'h27;
  localparam logic [7:0] OP_B1_WR_X4 = 8'h44, OP_B2_WR_X4 = 8'h47;
  localparam logic [7:0] OP_B1_PG_ER = 8'h83, OP_B2_PG_ER = 8'h86;
  localparam logic [7:0] OP_B1_PG = 8'h88, OP_B2_PG = 8'h89;
  localparam logic [7:0] OP_VIA_B1_ER = 8'h82, OP_VIA_B2_ER = 8'h85;
  localparam logic [7:0] OP_VIA_B1 = 8'h02, OP_PAGE_ER = 8'h81;
  localparam logic [7:0] OP_BLOCK_ER = 8'h50, OP_SECT_ER = 8'h7c;
  localparam logic [7:0] OP_SUSPEND = 8'hb0, OP_RESUME = 8'hd0;
  localparam logic [7:0] OP_PROT_RD = 8'h32, OP_LOCK_RD = 8'h35;
  localparam logic [7:0] OP_SEC_RD = 8'h77, OP_XFER1 = 8'h53;
  localparam logic [7:0] OP_XFER2 = 8'h55, OP_CMP1 = 8'h60;
  localparam logic [7:0] OP_CMP2 = 8'h61, OP_REWR1 = 8'h58;
  localparam logic [7:0] OP_REWR2 = 8'h59, OP_DPD = 8'hb9;
  localparam logic [7:0] OP_DPD_EXIT = 8'hab, OP_UDPD = 8'h79;
  localparam logic [7:0] OP_STAT_RD = 8'hd7, OP_ID_RD = 8'h9f;
  localparam logic [7:0] OP_CFG_RD = 8'h3f, OP_B1_RD_LEG = 8'h54;
  localparam logic [7:0] OP_B2_RD_LEG = 8'h56, OP_PG_RD_LEG = 8'h52;
  localparam logic [7:0] OP_RD_LEG2 = 8'h68, OP_STAT_LEG = 8'h57;

  // heads and following bytes of four-byte sequences
  localparam logic [7:0] HD_CFG = 8'h3d, HD_CHIP = 8'hc7;
  localparam logic [7:0] HD_FRZ = 8'h34, HD_SEC = 8'h9b;
  localparam logic [7:0] HD_RST = 8'hf0, SQ_ZERO = 8'h00;
  localparam logic [7:0] SQ_CFG1 = 8'h2a, SQ_GRP_PROT = 8'h7f;
  localparam logic [7:0] SQ_GRP_QUAD = 8'h81, SQ_GRP_PAGE = 8'h80;
  localparam logic [7:0] SQ_CHIP1 = 8'h94, SQ_CHIP2 = 8'h80;
  localparam logic [7:0] SQ_CHIP3 = 8'h9a, SQ_FRZ1 = 8'h55;
  localparam logic [7:0] SQ_FRZ2 = 8'haa, SQ_FRZ3 = 8'h40;
  localparam logic [7:0] TL_PROT_EN = 8'ha9, TL_PROT_DIS = 8'h9a;
  localparam logic [7:0] TL_PROT_ER = 8'hcf, TL_PROT_PGM = 8'hfc;
  localparam logic [7:0] TL_LOCK = 8'h30, TL_QUAD_EN = 8'h66;
  localparam logic [7:0] TL_QUAD_DIS = 8'h67, TL_PG_BIN = 8'ha6;
  localparam logic [7:0] TL_PG_STD = 8'ha7;

  typedef enum logic [5:0] {
    CMD_NONE, CMD_PAGE_RD, CMD_RD_LP, CMD_RD_LF, CMD_RD_HF, CMD_RD_X2,
    CMD_RD_X4, CMD_RD_LEG, CMD_B1_RD_LF, CMD_B2_RD_LF, CMD_B1_RD_HF,
    CMD_B2_RD_HF, CMD_B1_WR, CMD_B2_WR, CMD_B1_WR_X2, CMD_B2_WR_X2,
    CMD_B1_WR_X4, CMD_B2_WR_X4, CMD_B1_PG_ER, CMD_B2_PG_ER, CMD_B1_PG,
    CMD_B2_PG, CMD_VIA_B1_ER, CMD_VIA_B2_ER, CMD_VIA_B1, CMD_PAGE_ER,
    CMD_BLOCK_ER, CMD_SECT_ER, CMD_CHIP_ER, CMD_SUSPEND, CMD_RESUME,
    CMD_PROT_EN, CMD_PROT_DIS, CMD_PROT_ER, CMD_PROT_PGM, CMD_PROT_RD,
    CMD_LOCK, CMD_LOCK_RD, CMD_LOCK_FRZ, CMD_SEC_PGM, CMD_SEC_RD,
    CMD_XFER1, CMD_XFER2, CMD_CMP1, CMD_CMP2, CMD_REWR1, CMD_REWR2,
    CMD_DPD, CMD_DPD_EXIT, CMD_UDPD, CMD_STAT_RD, CMD_ID_RD, CMD_CFG_RD,
    CMD_QUAD_EN, CMD_QUAD_DIS, CMD_PG_BIN, CMD_PG_STD, CMD_SW_RST
  } sfcd_code_type;

  typedef struct packed {
    sfcd_code_type code;
    logic [7:0]    opcode;
    logic          legacy;
  } sfcd_cmd_type;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'b001,
    ST_SEQ    = 3'b010,
    ST_SKIP   = 3'b100
  } sfcd_state_type;

endpackage : sfcd_pkg

// ==== rtl/sfcd_shift.sv ====
`timescale 1ns/1ps
module sfcd_shift
#(
  parameter int BYTE_W = sfcd_pkg::BYTE_BITS
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              si,
  output logic [BYTE_W-1:0]      byte_o,
  output logic                   valid_o,
  output logic                   aligned_o
);

  localparam int CW = $clog2(BYTE_W);
  localparam logic [CW-1:0] CNT_LAST = CW'(BYTE_W - 1);

  generate
    if (BYTE_W < 2)
    begin : g_chk
      $error("sfcd_shift: BYTE_W must be at least 2");
    end
  endgenerate

  logic              sck_q_ff;
  logic [CW-1:0]     cnt_ff;
  logic [BYTE_W-1:0] sh_ff;
  logic [BYTE_W-1:0] byte_ff;
  logic              valid_ff;

  // modes 0 and 3 both sample on the rising edge of the serial clock
  wire               rise     = sck & ~sck_q_ff & ~cs_n;
  wire               last     = (cnt_ff == CNT_LAST);
  wire [BYTE_W-1:0]  nxt_sh   = {sh_ff[BYTE_W-2:0], si};

  assign byte_o    = byte_ff;
  assign valid_o   = valid_ff;
  // still shows the old count in the cycle chip select rises
  assign aligned_o = (cnt_ff == '0);

  // bit counter restarts with every frame, msb arrives first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_q_ff <= 1'b0;
      cnt_ff   <= '0;
      sh_ff    <= '0;
      byte_ff  <= '0;
      valid_ff <= 1'b0;
    end
    else
    begin
      sck_q_ff <= sck;
      valid_ff <= rise & last;
      if (cs_n)
        cnt_ff <= '0;
      else if (rise)
        cnt_ff <= last ? '0 : cnt_ff + 1'b1;
      if (rise)
        sh_ff <= nxt_sh;
      if (rise & last)
        byte_ff <= nxt_sh;
    end
  end

endmodule : sfcd_shift

// ==== rtl/sfcd_top.sv ====
`timescale 1ns/1ps
module sfcd_top
(
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic              SCK,
  input  wire logic              CS_N,
  input  wire logic              SI,
  output logic                   CMD_VALID,
  output sfcd_pkg::sfcd_cmd_type CMD
);

  // opcode to command, CMD_NONE for heads and unknown codes
  function automatic sfcd_pkg::sfcd_code_type decode_single(
    input logic [7:0] op
  );
    sfcd_pkg::sfcd_code_type c;
    c = sfcd_pkg::CMD_NONE;
    case (op)
      sfcd_pkg::OP_PAGE_RD:   c = sfcd_pkg::CMD_PAGE_RD;
      sfcd_pkg::OP_RD_LP:     c = sfcd_pkg::CMD_RD_LP;
      sfcd_pkg::OP_RD_LF:     c = sfcd_pkg::CMD_RD_LF;
      sfcd_pkg::OP_RD_HF:     c = sfcd_pkg::CMD_RD_HF;
      sfcd_pkg::OP_RD_HF2:    c = sfcd_pkg::CMD_RD_HF;
      sfcd_pkg::OP_RD_X2:     c = sfcd_pkg::CMD_RD_X2;
      sfcd_pkg::OP_RD_X4:     c = sfcd_pkg::CMD_RD_X4;
      sfcd_pkg::OP_B1_RD_LF:  c = sfcd_pkg::CMD_B1_RD_LF;
      sfcd_pkg::OP_B2_RD_LF:  c = sfcd_pkg::CMD_B2_RD_LF;
      sfcd_pkg::OP_B1_RD_HF:  c = sfcd_pkg::CMD_B1_RD_HF;
      sfcd_pkg::OP_B2_RD_HF:  c = sfcd_pkg::CMD_B2_RD_HF;
      sfcd_pkg::OP_B1_WR:     c = sfcd_pkg::CMD_B1_WR;
      sfcd_pkg::OP_B2_WR:     c = sfcd_pkg::CMD_B2_WR;
      sfcd_pkg::OP_B1_WR_X2:  c = sfcd_pkg::CMD_B1_WR_X2;
      sfcd_pkg::OP_B2_WR_X2:  c = sfcd_pkg::CMD_B2_WR_X2;
      sfcd_pkg::OP_B1_WR_X4:  c = sfcd_pkg::CMD_B1_WR_X4;
      sfcd_pkg::OP_B2_WR_X4:  c = sfcd_pkg::CMD_B2_WR_X4;
      sfcd_pkg::OP_B1_PG_ER:  c = sfcd_pkg::CMD_B1_PG_ER;
      sfcd_pkg::OP_B2_PG_ER:  c = sfcd_pkg::CMD_B2_PG_ER;
      sfcd_pkg::OP_B1_PG:     c = sfcd_pkg::CMD_B1_PG;
      sfcd_pkg::OP_B2_PG:     c = sfcd_pkg::CMD_B2_PG;
      sfcd_pkg::OP_VIA_B1_ER: c = sfcd_pkg::CMD_VIA_B1_ER;
      sfcd_pkg::OP_VIA_B2_ER: c = sfcd_pkg::CMD_VIA_B2_ER;
      sfcd_pkg::OP_VIA_B1:    c = sfcd_pkg::CMD_VIA_B1;
      // erase and suspend family, plain opcodes
      sfcd_pkg::OP_PAGE_ER:   c = sfcd_pkg::CMD_PAGE_ER;
      sfcd_pkg::OP_BLOCK_ER:  c = sfcd_pkg::CMD_BLOCK_ER;
      sfcd_pkg::OP_SECT_ER:   c = sfcd_pkg::CMD_SECT_ER;
      sfcd_pkg::OP_SUSPEND:   c = sfcd_pkg::CMD_SUSPEND;
      sfcd_pkg::OP_RESUME:    c = sfcd_pkg::CMD_RESUME;
      sfcd_pkg::OP_PROT_RD:   c = sfcd_pkg::CMD_PROT_RD;
      sfcd_pkg::OP_LOCK_RD:   c = sfcd_pkg::CMD_LOCK_RD;
      sfcd_pkg::OP_SEC_RD:    c = sfcd_pkg::CMD_SEC_RD;
      sfcd_pkg::OP_XFER1:     c = sfcd_pkg::CMD_XFER1;
      sfcd_pkg::OP_XFER2:     c = sfcd_pkg::CMD_XFER2;
      sfcd_pkg::OP_CMP1:      c = sfcd_pkg::CMD_CMP1;
      sfcd_pkg::OP_CMP2:      c = sfcd_pkg::CMD_CMP2;
      sfcd_pkg::OP_REWR1:     c = sfcd_pkg::CMD_REWR1;
      sfcd_pkg::OP_REWR2:     c = sfcd_pkg::CMD_REWR2;
      sfcd_pkg::OP_DPD:       c = sfcd_pkg::CMD_DPD;
      sfcd_pkg::OP_DPD_EXIT:  c = sfcd_pkg::CMD_DPD_EXIT;
      sfcd_pkg::OP_UDPD:      c = sfcd_pkg::CMD_UDPD;
      sfcd_pkg::OP_STAT_RD:   c = sfcd_pkg::CMD_STAT_RD;
      sfcd_pkg::OP_ID_RD:     c = sfcd_pkg::CMD_ID_RD;
      sfcd_pkg::OP_CFG_RD:    c = sfcd_pkg::CMD_CFG_RD;
      sfcd_pkg::OP_RD_LEG:    c = sfcd_pkg::CMD_RD_LEG;
      sfcd_pkg::OP_RD_LEG2:   c = sfcd_pkg::CMD_RD_LEG;
      sfcd_pkg::OP_B1_RD_LEG: c = sfcd_pkg::CMD_B1_RD_LF;
      sfcd_pkg::OP_B2_RD_LEG: c = sfcd_pkg::CMD_B2_RD_LF;
      sfcd_pkg::OP_PG_RD_LEG: c = sfcd_pkg::CMD_PAGE_RD;
      sfcd_pkg::OP_STAT_LEG:  c = sfcd_pkg::CMD_STAT_RD;
      default:                c = sfcd_pkg::CMD_NONE;
    endcase
    return c;
  endfunction : decode_single

  // older opcodes are flagged so the owner can count their use
  function automatic logic is_legacy(input logic [7:0] op);
    return (op == sfcd_pkg::OP_RD_LEG)    || (op == sfcd_pkg::OP_RD_LEG2) ||
           (op == sfcd_pkg::OP_B1_RD_LEG) || (op == sfcd_pkg::OP_B2_RD_LEG) ||
           (op == sfcd_pkg::OP_PG_RD_LEG) || (op == sfcd_pkg::OP_STAT_LEG);
  endfunction : is_legacy

  // first byte of a four-byte sequence
  function automatic logic is_head(input logic [7:0] op);
    return (op == sfcd_pkg::HD_CFG) || (op == sfcd_pkg::HD_CHIP) ||
           (op == sfcd_pkg::HD_FRZ) || (op == sfcd_pkg::HD_SEC)  ||
           (op == sfcd_pkg::HD_RST);
  endfunction : is_head

  // second and third bytes of each sequence
  function automatic logic mid_ok(
    input logic [7:0] head,
    input logic [1:0] idx,
    input logic [7:0] b
  );
    logic ok;
    ok = 1'b0;
    if (idx == 2'd1)
    begin
      case (head)
        sfcd_pkg::HD_CFG:  ok = (b == sfcd_pkg::SQ_CFG1);
        sfcd_pkg::HD_CHIP: ok = (b == sfcd_pkg::SQ_CHIP1);
        sfcd_pkg::HD_FRZ:  ok = (b == sfcd_pkg::SQ_FRZ1);
        default:           ok = (b == sfcd_pkg::SQ_ZERO);
      endcase
    end
    else
    begin
      case (head)
        sfcd_pkg::HD_CFG:  ok = (b == sfcd_pkg::SQ_GRP_PROT) ||
                                (b == sfcd_pkg::SQ_GRP_QUAD) ||
                                (b == sfcd_pkg::SQ_GRP_PAGE);
        sfcd_pkg::HD_CHIP: ok = (b == sfcd_pkg::SQ_CHIP2);
        sfcd_pkg::HD_FRZ:  ok = (b == sfcd_pkg::SQ_FRZ2);
        default:           ok = (b == sfcd_pkg::SQ_ZERO);
      endcase
    end
    return ok;
  endfunction : mid_ok

  // fourth byte, given head and third byte
  function automatic sfcd_pkg::sfcd_code_type decode_tail(
    input logic [7:0] head,
    input logic [7:0] grp,
    input logic [7:0] b
  );
    sfcd_pkg::sfcd_code_type c;
    c = sfcd_pkg::CMD_NONE;
    if (head == sfcd_pkg::HD_CFG && grp == sfcd_pkg::SQ_GRP_PROT)
    begin
      if (b == sfcd_pkg::TL_PROT_EN)  c = sfcd_pkg::CMD_PROT_EN;
      if (b == sfcd_pkg::TL_PROT_DIS) c = sfcd_pkg::CMD_PROT_DIS;
      if (b == sfcd_pkg::TL_PROT_ER)  c = sfcd_pkg::CMD_PROT_ER;
      if (b == sfcd_pkg::TL_PROT_PGM) c = sfcd_pkg::CMD_PROT_PGM;
      if (b == sfcd_pkg::TL_LOCK)     c = sfcd_pkg::CMD_LOCK;
    end
    else if (head == sfcd_pkg::HD_CFG && grp == sfcd_pkg::SQ_GRP_QUAD)
    begin
      if (b == sfcd_pkg::TL_QUAD_EN)  c = sfcd_pkg::CMD_QUAD_EN;
      if (b == sfcd_pkg::TL_QUAD_DIS) c = sfcd_pkg::CMD_QUAD_DIS;
    end
    else if (head == sfcd_pkg::HD_CFG)
    begin
      if (b == sfcd_pkg::TL_PG_BIN)   c = sfcd_pkg::CMD_PG_BIN;
      if (b == sfcd_pkg::TL_PG_STD)   c = sfcd_pkg::CMD_PG_STD;
    end
    else if (head == sfcd_pkg::HD_CHIP && b == sfcd_pkg::SQ_CHIP3)
      c = sfcd_pkg::CMD_CHIP_ER;
    else if (head == sfcd_pkg::HD_FRZ && b == sfcd_pkg::SQ_FRZ3)
      c = sfcd_pkg::CMD_LOCK_FRZ;
    else if (head == sfcd_pkg::HD_SEC && b == sfcd_pkg::SQ_ZERO)
      c = sfcd_pkg::CMD_SEC_PGM;
    else if (head == sfcd_pkg::HD_RST && b == sfcd_pkg::SQ_ZERO)
      c = sfcd_pkg::CMD_SW_RST;
    return c;
  endfunction : decode_tail

  localparam logic [1:0] IDX_LAST = 2'(sfcd_pkg::SEQ_LEN - 1);

  logic [7:0]               rx_byte;
  logic                     rx_vld;
  logic                     rx_aligned;
  logic                     csn_q_ff;
  sfcd_pkg::sfcd_state_type state_ff;
  sfcd_pkg::sfcd_state_type nxt_state;
  logic [1:0]               idx_ff;
  logic [1:0]               nxt_idx;
  logic [7:0]               head_ff;
  logic [7:0]               nxt_head;
  logic [7:0]               grp_ff;
  logic [7:0]               nxt_grp;
  logic                     pend_ff;
  logic                     nxt_pend;
  logic                     vld_ff;
  logic                     nxt_vld;
  sfcd_pkg::sfcd_cmd_type   cmd_ff;
  sfcd_pkg::sfcd_cmd_type   nxt_cmd;

  // serial to byte conversion
  sfcd_shift #(
    .BYTE_W    (sfcd_pkg::BYTE_BITS)
  ) u_shift (
    .clk       (CLK),
    .rst_n     (RSTN),
    .sck       (SCK),
    .cs_n      (CS_N),
    .si        (SI),
    .byte_o    (rx_byte),
    .valid_o   (rx_vld),
    .aligned_o (rx_aligned)
  );

  // decode of the byte just received
  wire                          csn_rise  = CS_N & ~csn_q_ff;
  wire sfcd_pkg::sfcd_code_type one_code  = decode_single(rx_byte);
  wire                          one_leg   = is_legacy(rx_byte);
  wire                          head_hit  = is_head(rx_byte);
  wire                          mid_hit   = mid_ok(head_ff, idx_ff, rx_byte);
  wire sfcd_pkg::sfcd_code_type tail_code =
    decode_tail(head_ff, grp_ff, rx_byte);
  wire                          tail_last = (idx_ff == IDX_LAST);

  assign CMD_VALID = vld_ff;
  assign CMD       = cmd_ff;

  // byte-by-byte sequence tracking
  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_head  = head_ff;
    nxt_grp   = grp_ff;
    nxt_pend  = pend_ff;
    nxt_vld   = 1'b0;
    nxt_cmd   = cmd_ff;
    if (rx_vld)
    begin
      unique case (state_ff)
        sfcd_pkg::ST_OPCODE:
        begin
          if (head_hit)
          begin
            nxt_state = sfcd_pkg::ST_SEQ;
            nxt_head  = rx_byte;
            nxt_idx   = 2'd1;
          end
          else
          begin
            nxt_state = sfcd_pkg::ST_SKIP;
            if (one_code != sfcd_pkg::CMD_NONE)
            begin
              nxt_vld = 1'b1;
              nxt_cmd = '{code: one_code, opcode: rx_byte, legacy: one_leg};
            end
          end
        end
        sfcd_pkg::ST_SEQ:
        begin
          if (!tail_last)
          begin
            nxt_state = mid_hit ? sfcd_pkg::ST_SEQ : sfcd_pkg::ST_SKIP;
            nxt_idx   = idx_ff + 2'd1;
            nxt_grp   = rx_byte;
          end
          else
          begin
            nxt_state = sfcd_pkg::ST_SKIP;
            if (tail_code == sfcd_pkg::CMD_SW_RST)
              nxt_pend = 1'b1;
            else if (tail_code != sfcd_pkg::CMD_NONE)
            begin
              nxt_vld = 1'b1;
              nxt_cmd = '{code: tail_code, opcode: head_ff, legacy: 1'b0};
            end
          end
        end
        sfcd_pkg::ST_SKIP:
        begin
          // trailing address, dummy and data bytes are not ours
          nxt_state = sfcd_pkg::ST_SKIP;
        end
      endcase
    end
    if (csn_rise)
    begin
      if (nxt_pend && rx_aligned)
      begin
        nxt_vld = 1'b1;
        nxt_cmd = '{code: sfcd_pkg::CMD_SW_RST, opcode: sfcd_pkg::HD_RST,
                    legacy: 1'b0};
      end
      nxt_state = sfcd_pkg::ST_OPCODE;
      nxt_idx   = 2'd0;
      nxt_pend  = 1'b0;
    end
  end

  // state and output registers
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      csn_q_ff <= 1'b1;
      state_ff <= sfcd_pkg::ST_OPCODE;
      idx_ff   <= 2'd0;
      head_ff  <= 8'h00;
      grp_ff   <= 8'h00;
      pend_ff  <= 1'b0;
      vld_ff   <= 1'b0;
      cmd_ff   <= '{code: sfcd_pkg::CMD_NONE, opcode: 8'h00, legacy: 1'b0};
    end
    else
    begin
      csn_q_ff <= CS_N;
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      head_ff  <= nxt_head;
      grp_ff   <= nxt_grp;
      pend_ff  <= nxt_pend;
      vld_ff   <= nxt_vld;
      cmd_ff   <= nxt_cmd;
    end
  end

endmodule : sfcd_top

// ==== sim/sfcd_checker.sv ====
`timescale 1ns/1ps
module sfcd_checker
(
  input wire logic                   CLK,
  input wire logic                   RSTN,
  input wire logic                   SCK,
  input wire logic                   CS_N,
  input wire logic                   SI,
  input wire logic                   CMD_VALID,
  input wire sfcd_pkg::sfcd_cmd_type CMD
);
  logic        sck_ff;
  logic        cs_ff;
  logic [7:0]  sh_ff;
  logic [15:0] cnt_ff;
  logic        take;
  logic        byte_done;
  logic        first_done;
  logic        cs_rise;
  logic [7:0]  cur_byte;

  // a bit counts only on a seen clock rise inside a frame
  assign take       = SCK && !sck_ff && !CS_N;
  assign cur_byte   = {sh_ff[6:0], SI};
  assign byte_done  = take && (cnt_ff[2:0] == 3'h7);
  assign first_done = take && (cnt_ff == 16'h0007);
  assign cs_rise    = CS_N && !cs_ff;

  // shadow of the frame, bit count cleared while deselected
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sck_ff <= 1'b0;
      cs_ff  <= 1'b1;
      sh_ff  <= 8'h00;
      cnt_ff <= 16'h0000;
    end
    else
    begin
      sck_ff <= SCK;
      cs_ff  <= CS_N;
      sh_ff  <= take ? cur_byte : sh_ff;
      cnt_ff <= CS_N ? 16'h0000 : (take ? cnt_ff + 16'h0001 : cnt_ff);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_pulse_single: assert property (CMD_VALID |=> !CMD_VALID)
    else $error("command strobe longer than one cycle");
  a_cmd_holds: assert property (!CMD_VALID |-> $stable(CMD))
    else $error("command changed without strobe");
  a_valid_cause: assert property (CMD_VALID |->
    $past(byte_done, 2) || $past(cs_rise, 1))
    else $error("strobe without completed byte or release");
  a_stat_read: assert property (first_done && cur_byte == 8'hd7 |->
    ##2 (CMD_VALID && CMD.code == sfcd_pkg::CMD_STAT_RD))
    else $error("status read not decoded in time");
  a_page_read: assert property (first_done && cur_byte == 8'hd2 |->
    ##2 (CMD_VALID && CMD.code == sfcd_pkg::CMD_PAGE_RD))
    else $error("page read not decoded in time");
  a_legacy_flag: assert property (CMD_VALID |-> CMD.legacy ==
    (CMD.opcode inside {8'he8, 8'h68, 8'h54, 8'h56, 8'h52, 8'h57}))
    else $error("older opcode flag wrong");
  a_head_waits: assert property (first_done &&
    cur_byte inside {8'h3d, 8'hc7, 8'h34, 8'h9b, 8'hf0} |-> ##2 !CMD_VALID)
    else $error("sequence decided on its first byte");
  a_unknown_quiet: assert property (first_done && cur_byte == 8'hff |->
    ##1 (!CMD_VALID) [*8])
    else $error("unknown opcode produced a command");
  a_reset_align: assert property (CMD_VALID &&
    CMD.code == sfcd_pkg::CMD_SW_RST |->
    $past(cnt_ff, 1) >= 16'd32 && ($past(cnt_ff, 1) & 16'h0007) == 16'h0000)
    else $error("reset accepted on short or unaligned frame");

  // main scenarios seen
  c_reset: cover property (CMD_VALID && CMD.code == sfcd_pkg::CMD_SW_RST);
  c_legacy: cover property (CMD_VALID && CMD.legacy);
  c_chip: cover property (CMD_VALID && CMD.code == sfcd_pkg::CMD_CHIP_ER);
endmodule : sfcd_checker

bind sfcd_top sfcd_checker u_sfcd_checker (.CLK(CLK), .RSTN(RSTN),
  .SCK(SCK), .CS_N(CS_N), .SI(SI), .CMD_VALID(CMD_VALID), .CMD(CMD));

// ==== sim/sfcd_host.sv ====
`timescale 1ns/1ps
module sfcd_host
(
  input  wire logic CLK,
  output logic      SCK,
  output logic      CS_N,
  output logic      SI
);
  // idle: deselected, serial clock parked low
  initial
  begin
    SCK  = 1'b0;
    CS_N = 1'b1;
    SI   = 1'b0;
  end

  // bytes msb first, release after last bit
  task automatic send(input logic [39:0] data, input int nbits);
    @(posedge CLK);
    CS_N <= 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      SI <= data[39 - i];
      repeat (2) @(posedge CLK);
      SCK <= 1'b1;
      repeat (2) @(posedge CLK);
      SCK <= 1'b0;
    end
    repeat (2) @(posedge CLK);
    CS_N <= 1'b1;
    // a deselected line must not look like the last bit
    SI <= ~SI;
    repeat (3) @(posedge CLK);
  endtask : send
endmodule : sfcd_host

// ==== sim/serial_flash_command_decoder_bench.sv ====
`timescale 1ns/1ps
module serial_flash_command_decoder_bench;
  logic                   clk;
  logic                   rstn;
  wire                    sck;
  wire                    cs_n;
  wire                    si;
  logic                   cmd_valid;
  sfcd_pkg::sfcd_cmd_type cmd;
  int                     n_errors = 0;
  int                     n_tests = 0;
  int                     n_seen = 0;

  sfcd_top u_sfcd_top (.CLK(clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n),
    .SI(si), .CMD_VALID(cmd_valid), .CMD(cmd));
  sfcd_host u_sfcd_host (.CLK(clk), .SCK(sck), .CS_N(cs_n), .SI(si));

  // clock and strobe counter
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (cmd_valid === 1'b1)
      n_seen++;

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // one frame; the held command is only judged when a strobe is expected
  task automatic run(input logic [39:0] data, input int nbits,
                     input int n_exp, input logic [7:0] code, input logic leg);
    n_seen = 0;
    u_sfcd_host.send(data, nbits);
    repeat (6) @(posedge clk);
    check(n_seen, n_exp);
    if (n_exp == 1)
      check(cmd, {code[5:0], data[39:32], leg});
  endtask : run

  // table entries are opcode then expected code number
  task automatic t_reads;
    logic [15:0] t [$] = '{16'hd201, 16'h0102, 16'h0303, 16'h0b04,
      16'h1b04, 16'h3b05, 16'h6b06, 16'hd108, 16'hd309, 16'hd40a, 16'hd60b};
    logic [15:0] o [$] = '{16'he807, 16'h6807, 16'h5408, 16'h5609,
      16'h5201, 16'h5732};
    foreach (t[i])
      run({t[i][15:8], 24'h5a0000, 8'h00}, 16, 1, t[i][7:0], 1'b0);
    foreach (o[i])
      run({o[i][15:8], 32'h5a000000}, 16, 1, o[i][7:0], 1'b1);
    $display("read opcodes done");
  endtask : t_reads

  task automatic t_program;
    logic [15:0] t [$] = '{16'h840c, 16'h870d, 16'h240e, 16'h270f, 16'h4410,
      16'h4711, 16'h8312, 16'h8613, 16'h8814, 16'h8915, 16'h8216, 16'h8517,
      16'h0218, 16'h5329, 16'h552a, 16'h602b, 16'h612c, 16'h582d, 16'h592e,
      16'h8119, 16'h501a, 16'h7c1b, 16'hb01d, 16'hd01e};
    foreach (t[i])
      run({t[i][15:8], 32'h5a000000}, 16, 1, t[i][7:0], 1'b0);
    $display("program opcodes done");
  endtask : t_program

  task automatic t_status;
    logic [15:0] t [$] = '{16'h3223, 16'h3525, 16'h7728, 16'hb92f, 16'hab30,
      16'h7931, 16'hd732, 16'h9f33, 16'h3f34};
    foreach (t[i])
      run({t[i][15:8], 32'h5a000000}, 16, 1, t[i][7:0], 1'b0);
    $display("register and power opcodes done");
  endtask : t_status

  // four-byte sequences, then expected code number
  task automatic t_sequences;
    logic [39:0] t [$] = '{40'h3d2a7fa91f, 40'h3d2a7f9a20, 40'h3d2a7fcf21,
      40'h3d2a7ffc22, 40'h3d2a7f3024, 40'hc794809a1c, 40'h3455aa4026,
      40'h9b00000027, 40'h3d2a816635, 40'h3d2a816736, 40'h3d2a80a637,
      40'h3d2a80a738};
    foreach (t[i])
      run({t[i][39:8], 8'h00}, 32, 1, t[i][7:0], 1'b0);
    $display("sequences done");
  endtask : t_sequences

  task automatic t_reset;
    run(40'hf000000000, 32, 1, 8'h39, 1'b0);
    run(40'hf000000000, 36, 0, 8'h00, 1'b0);
    run(40'hf000000000, 24, 0, 8'h00, 1'b0);
    run(40'hf0000000a5, 40, 1, 8'h39, 1'b0);
    $display("software reset done");
  endtask : t_reset

  task automatic t_refuse;
    run(40'hff5a000000, 16, 0, 8'h00, 1'b0);
    run(40'h3d2a7f0000, 32, 0, 8'h00, 1'b0);
    run(40'hc794809b00, 32, 0, 8'h00, 1'b0);
    run(40'hc794800000, 24, 0, 8'h00, 1'b0);
    run(40'h9b00000100, 32, 0, 8'h00, 1'b0);
    run(40'hd700000000, 7, 0, 8'h00, 1'b0);
    run(40'hd7d7000000, 16, 1, 8'h32, 1'b0);
    $display("refusals done");
  endtask : t_refuse

  // watchdog, well past the few thousand cycles the tests need
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    give_verdict;
  end

  // main sequence
  initial
  begin
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reads;
    t_program;
    t_status;
    t_sequences;
    t_reset;
    t_refuse;
    give_verdict;
  end
endmodule : serial_flash_command_decoder_bench
